// File: pkg/cbwc_pkg.sv
// Package with register map, field layouts, reset values and timing counts of the control slice.
package cbwc_pkg;

  // Register byte addresses on the register port.
  localparam logic [7:0] CBWC_ADDR_BACKUP_OVP_WATCHDOG = 8'h10;
  localparam logic [7:0] CBWC_ADDR_ADAPTER_SHIPSWITCH  = 8'h11;

  // Whole-register reset values.
  localparam logic [7:0] CBWC_RESET_BACKUP_OVP_WATCHDOG = 8'h85;
  localparam logic [7:0] CBWC_RESET_ADAPTER_SHIPSWITCH  = 8'h40;

  // Value read back from an unmapped address.
  localparam logic [7:0] CBWC_UNMAPPED_READ = 8'h00;

  // Field layout of backup_ovp_watchdog_control, most significant field first.
  typedef struct packed {
    logic [1:0] backup_trigger_ratio;     // Bits 7-6.
    logic [1:0] input_overvoltage_level;  // Bits 5-4.
    logic       watchdog_kick;            // Bit 3.
    logic [2:0] watchdog_period;          // Bits 2-0.
  } cbwc_backup_ovp_watchdog_t;

  // Field layout of adapter_detect_shipswitch_control, most significant field first.
  typedef struct packed {
    logic       forced_adapter_detection;       // Bit 7.
    logic       auto_adapter_detection_enable;  // Bit 6.
    logic       hv_port_twelve_volt_enable;     // Bit 5.
    logic       hv_port_nine_volt_enable;       // Bit 4.
    logic       hv_port_handshake_enable;       // Bit 3.
    logic [1:0] ship_switch_mode_request;       // Bits 2-1.
    logic       ship_switch_delay_select;       // Bit 0.
  } cbwc_adapter_shipswitch_t;

  // One register access request from the serial front end.
  typedef struct packed {
    logic       write;  // Write strobe, one cycle.
    logic       read;   // Read strobe, one cycle.
    logic [7:0] addr;   // Register address.
    logic [7:0] wdata;  // Write data.
  } cbwc_reg_req_t;

  // Ship-switch mode request codes.
  localparam logic [1:0] CBWC_SHIP_IDLE        = 2'h0;
  localparam logic [1:0] CBWC_SHIP_SHUTDOWN    = 2'h1;
  localparam logic [1:0] CBWC_SHIP_SHIP_MODE   = 2'h2;
  localparam logic [1:0] CBWC_SHIP_POWER_RESET = 2'h3;

  // Backup trigger ratios in percent of the input voltage regulation limit.
  localparam logic [6:0] CBWC_RATIO_PCT_0 = 7'h28;
  localparam logic [6:0] CBWC_RATIO_PCT_1 = 7'h3C;
  localparam logic [6:0] CBWC_RATIO_PCT_2 = 7'h50;
  localparam logic [6:0] CBWC_RATIO_PCT_3 = 7'h64;
  localparam logic [6:0] CBWC_FULL_PCT    = 7'h64;

  // Input over-voltage trip levels in millivolts.
  localparam logic [15:0] CBWC_OVP_MV_0 = 16'h6590;
  localparam logic [15:0] CBWC_OVP_MV_1 = 16'h55F0;
  localparam logic [15:0] CBWC_OVP_MV_2 = 16'h2EE0;
  localparam logic [15:0] CBWC_OVP_MV_3 = 16'h1B58;

  // Watchdog periods as multiples of the half-second base tick.
  localparam logic [8:0] CBWC_WD_MULT_1 = 9'h001;
  localparam logic [8:0] CBWC_WD_MULT_2 = 9'h002;
  localparam logic [8:0] CBWC_WD_MULT_3 = 9'h004;
  localparam logic [8:0] CBWC_WD_MULT_4 = 9'h028;
  localparam logic [8:0] CBWC_WD_MULT_5 = 9'h050;
  localparam logic [8:0] CBWC_WD_MULT_6 = 9'h0A0;
  localparam logic [8:0] CBWC_WD_MULT_7 = 9'h140;

  // Timing, in the unit as stated and then in clock cycles.
  localparam longint CBWC_CLOCK_HZ          = 100_000_000;
  localparam longint CBWC_WD_BASE_MS        = 500;
  localparam longint CBWC_WD_BASE_CYCLES    = CBWC_WD_BASE_MS * CBWC_CLOCK_HZ / 1000;
  localparam longint CBWC_SHIP_DELAY_S      = 10;
  localparam longint CBWC_SHIP_DELAY_CYCLES = CBWC_SHIP_DELAY_S * CBWC_CLOCK_HZ;
  localparam int     CBWC_COUNT_W           = 34;

endpackage : cbwc_pkg

// File: core/cbwc_top.sv
// Backup, over-voltage, watchdog, adapter detection and ship-switch control registers.
`timescale 1ns/100ps

// Overview of operation
// R1 - Backup enabled: engage reverse supply below threshold.
// R2 - Threshold ratio codes 40/60/80/100 percent.
// R3 - Over-voltage level codes 26/22/12/7 volts.
// R4 - Kick restarts watchdog, bit self-clears.
// R5 - Period codes: off, 0.5s up to 160s.
// R6 - Forced detection starts, clears when done.
// R7 - Auto detection on plug-in when enabled.
// R8 - Separate 12V and 9V request enables.
// R9 - Handshake only attempted when enabled.
// R10 - Ship-switch mode request codes, idle default.
// R11 - Ten second delay unless delay bypassed.
// R12 - Watchdog expiry resets watchdog-resettable fields.
// R13 - Register reset restores every field.
module cbwc_top
  import cbwc_pkg::*;
#(
  parameter longint WD_BASE_CYCLES    = CBWC_WD_BASE_CYCLES,
  parameter longint SHIP_DELAY_CYCLES = CBWC_SHIP_DELAY_CYCLES
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          enable,
  input  wire cbwc_reg_req_t reg_req,
  output logic [7:0]         reg_rdata,
  output logic               reg_rdata_valid,
  input  wire logic          register_reset_request,
  input  wire logic          backup_enable,
  input  wire logic [15:0]   bus_voltage_mv,
  input  wire logic [15:0]   input_voltage_regulation_limit,
  input  wire logic [15:0]   input_voltage_mv,
  input  wire logic          source_plugged,
  input  wire logic          detection_done,
  output logic               backup_engage,
  output logic               overvoltage_trip,
  output logic               watchdog_expired,
  output logic               detection_start,
  output logic               hv_port_handshake_enable,
  output logic               hv_port_nine_volt_enable,
  output logic               hv_port_twelve_volt_enable,
  output logic               ship_action_strobe,
  output logic [1:0]         ship_action_mode
);

  // Scales a millivolt value by a percentage; used on both sides of the backup compare.
  function automatic logic [22:0] scale_pct(input logic [15:0] value, input logic [6:0] pct);
    scale_pct = 23'(value) * 23'(pct);
  endfunction : scale_pct

  // Ship-switch sequencer states, one-hot.
  // One-hot codes cost a flop per state but keep every state test to one bit.
  typedef enum logic [2:0] {
    CBWC_ST_IDLE = 3'b001,
    CBWC_ST_WAIT = 3'b010,
    CBWC_ST_ACT  = 3'b100
  } cbwc_ship_state_t;

  cbwc_backup_ovp_watchdog_t   ctrl_a;         // Backup, over-voltage and watchdog register.
  cbwc_adapter_shipswitch_t    ctrl_b;         // Adapter detection and ship-switch register.
  cbwc_backup_ovp_watchdog_t   wdata_a;        // Write data seen through the first layout.
  cbwc_adapter_shipswitch_t    wdata_b;        // Write data seen through the second layout.
  logic                        write_a;        // Write strobe aimed at the first register.
  logic                        write_b;        // Write strobe aimed at the second register.
  logic [CBWC_COUNT_W-1:0]     wd_count;       // Cycles since the last watchdog restart.
  logic [CBWC_COUNT_W-1:0]     wd_limit;       // Cycles in the selected watchdog period.
  logic [8:0]                  wd_mult;        // Half-second ticks in the selected period.
  logic                        wd_fire;        // Watchdog period elapsed this cycle.
  logic [6:0]                  ratio_pct;      // Selected backup trigger ratio.
  logic [15:0]                 ovp_level_mv;   // Selected over-voltage trip level.
  cbwc_ship_state_t            ship_state;     // Current ship-switch sequencer state.
  logic [CBWC_COUNT_W-1:0]     ship_count;     // Cycles spent waiting out the delay.
  logic [1:0]                  ship_mode_held; // Mode captured when the request was made.

  // Limitations a user must know:
  // Any write to the first register restarts the watchdog, even one with the kick clear.
  // The ship delay is counted in clock cycles, so it is only as exact as the clock.
  // Holding enable low freezes the delay as well, so the action comes that much later.
  // A write to an unmapped address is dropped without any error indication.
  // A register reset request beats a host write that arrives in the same cycle.

  // The front end hands us whole bytes; view them through each register layout.
  assign wdata_a = cbwc_backup_ovp_watchdog_t'(reg_req.wdata);
  assign wdata_b = cbwc_adapter_shipswitch_t'(reg_req.wdata);
  assign write_a = reg_req.write && (reg_req.addr == CBWC_ADDR_BACKUP_OVP_WATCHDOG);
  assign write_b = reg_req.write && (reg_req.addr == CBWC_ADDR_ADAPTER_SHIPSWITCH);

  // High-voltage port controls go straight out of the register flops.
  // Only a register reset clears them; watchdog expiry leaves them alone.
  assign hv_port_handshake_enable   = ctrl_b.hv_port_handshake_enable;    // R9
  assign hv_port_nine_volt_enable   = ctrl_b.hv_port_nine_volt_enable;    // R8
  assign hv_port_twelve_volt_enable = ctrl_b.hv_port_twelve_volt_enable;  // R8

  // Decodes the period code into half-second ticks; code zero means the watchdog is off.
  always_comb begin
    case (ctrl_a.watchdog_period)  // R5
      3'h1:    wd_mult = CBWC_WD_MULT_1;
      3'h2:    wd_mult = CBWC_WD_MULT_2;
      3'h3:    wd_mult = CBWC_WD_MULT_3;
      3'h4:    wd_mult = CBWC_WD_MULT_4;
      3'h5:    wd_mult = CBWC_WD_MULT_5;
      3'h6:    wd_mult = CBWC_WD_MULT_6;
      3'h7:    wd_mult = CBWC_WD_MULT_7;
      // Code zero disables the watchdog, so its period is empty.
      default: wd_mult = 9'h000;
    endcase
  end

  // The limit is a product rather than a table so the base tick stays one parameter.
  // The product is 34 bits wide, enough for the longest period at the full clock rate.
  assign wd_limit = CBWC_COUNT_W'(WD_BASE_CYCLES) * CBWC_COUNT_W'(wd_mult);
  // A pending kick holds off expiry in the same cycle, so a late kick is never lost.
  assign wd_fire  = (wd_mult != 9'h000) && !ctrl_a.watchdog_kick &&
                    (wd_count == wd_limit - CBWC_COUNT_W'(1));  // R12

  // Decodes the backup trigger ratio.
  // Code three selects the full regulation limit.
  always_comb begin
    case (ctrl_a.backup_trigger_ratio)  // R2
      2'h0:    ratio_pct = CBWC_RATIO_PCT_0;
      2'h1:    ratio_pct = CBWC_RATIO_PCT_1;
      2'h2:    ratio_pct = CBWC_RATIO_PCT_2;
      default: ratio_pct = CBWC_RATIO_PCT_3;
    endcase
  end

  // Decodes the input over-voltage trip level.
  // Higher codes select lower trip levels; the reset code selects the highest level, 26 volts.
  always_comb begin
    case (ctrl_a.input_overvoltage_level)  // R3
      2'h0:    ovp_level_mv = CBWC_OVP_MV_0;
      2'h1:    ovp_level_mv = CBWC_OVP_MV_1;
      2'h2:    ovp_level_mv = CBWC_OVP_MV_2;
      default: ovp_level_mv = CBWC_OVP_MV_3;
    endcase
  end

  // First register: register reset beats everything, and a host write beats hardware clears.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_a <= cbwc_backup_ovp_watchdog_t'(CBWC_RESET_BACKUP_OVP_WATCHDOG);
    end else if (enable) begin
      if (register_reset_request) begin
        // Threshold and period fields come back only through this path.
        ctrl_a <= cbwc_backup_ovp_watchdog_t'(CBWC_RESET_BACKUP_OVP_WATCHDOG);  // R13
      end else begin
        // The kick is the only field here that watchdog expiry touches.
        if (wd_fire) begin
          ctrl_a.watchdog_kick <= 1'b0;  // R12
        end else if (ctrl_a.watchdog_kick) begin
          // The counter restarts on this same edge, so one cycle of the kick is enough.
          ctrl_a.watchdog_kick <= 1'b0;  // R4
        end
        // Placed last so a fresh kick written now survives the clear above.
        if (write_a) begin
          ctrl_a <= wdata_a;
        end
      end
    end
  end

  // Second register: detection bits are watchdog-resettable, the rest only by register reset.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_b <= cbwc_adapter_shipswitch_t'(CBWC_RESET_ADAPTER_SHIPSWITCH);
    end else if (enable) begin
      if (register_reset_request) begin
        // Unlike expiry, this also clears the high-voltage and ship fields.
        ctrl_b <= cbwc_adapter_shipswitch_t'(CBWC_RESET_ADAPTER_SHIPSWITCH);  // R13
      end else begin
        if (wd_fire) begin
          ctrl_b.forced_adapter_detection      <= 1'b0;  // R12
          ctrl_b.auto_adapter_detection_enable <= 1'b1;  // R12
        end else if (detection_done) begin
          // Completion ends the forced request; the host may ask again at once.
          ctrl_b.forced_adapter_detection <= 1'b0;  // R6
        end
        // A host write in the same cycle as completion wins, so a new request is kept.
        if (write_b) begin
          ctrl_b <= wdata_b;
        end
      end
    end
  end

  // Watchdog counter; a kick or a new period setting starts the period afresh.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wd_count         <= '0;
      watchdog_expired <= 1'b0;
    end else if (enable) begin
      watchdog_expired <= wd_fire;
      if (register_reset_request || ctrl_a.watchdog_kick || write_a || wd_fire) begin
        wd_count <= '0;  // R4
      end else if (wd_mult != 9'h000) begin
        wd_count <= wd_count + CBWC_COUNT_W'(1);  // R5
      end else begin
        // A disabled watchdog keeps its count parked at zero.
        wd_count <= '0;
      end
    end
  end

  // Detection launch pulse, from a forced request or from a plug-in with auto detection.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      detection_start <= 1'b0;
    end else if (enable) begin
      if (write_b && wdata_b.forced_adapter_detection && !register_reset_request) begin
        detection_start <= 1'b1;  // R6
      end else if (source_plugged && ctrl_b.auto_adapter_detection_enable) begin
        detection_start <= 1'b1;  // R7
      end else begin
        // A level here would relaunch detection every cycle, hence the pulse.
        detection_start <= 1'b0;
      end
    end
  end

  // Ship-switch sequencer; a new write restarts it, and idle or register reset cancels it.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ship_state         <= CBWC_ST_IDLE;
      ship_count         <= '0;
      ship_mode_held     <= CBWC_SHIP_IDLE;
      ship_action_strobe <= 1'b0;
      ship_action_mode   <= CBWC_SHIP_IDLE;
    end else if (enable) begin
      ship_action_strobe <= 1'b0;
      if (register_reset_request) begin
        // A register reset drops any pending action, delayed or not.
        ship_state <= CBWC_ST_IDLE;  // R13
      end else if (write_b) begin
        // Every write to the second register restarts the sequence, hv bits included.
        ship_count     <= '0;
        ship_mode_held <= wdata_b.ship_switch_mode_request;  // R10
        if (wdata_b.ship_switch_mode_request == CBWC_SHIP_IDLE) begin
          ship_state <= CBWC_ST_IDLE;  // R10
        end else if (wdata_b.ship_switch_delay_select) begin
          ship_state <= CBWC_ST_ACT;  // R11
        end else begin
          ship_state <= CBWC_ST_WAIT;  // R11
        end
      end else begin
        case (ship_state)
          CBWC_ST_IDLE: begin
            // Nothing pending; keep the delay counter clear for the next request.
            ship_count <= '0;
          end
          CBWC_ST_WAIT: begin
            // One cycle of latency follows the count, well inside the delay tolerance.
            if (ship_count == CBWC_COUNT_W'(SHIP_DELAY_CYCLES) - CBWC_COUNT_W'(1)) begin
              ship_state <= CBWC_ST_ACT;  // R11
            end else begin
              ship_count <= ship_count + CBWC_COUNT_W'(1);
            end
          end
          CBWC_ST_ACT: begin
            // The mode is kept after the strobe so the far side may look at it later.
            ship_action_strobe <= 1'b1;  // R10
            ship_action_mode   <= ship_mode_held;
            ship_state         <= CBWC_ST_IDLE;
          end
          default: begin
            // Only an upset can reach a code that is not one-hot; fall back to idle.
            ship_state <= CBWC_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Backup and over-voltage comparators, registered so the outputs never glitch.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      backup_engage    <= 1'b0;
      overvoltage_trip <= 1'b0;
    end else if (enable) begin
      // Cross-multiplied compare avoids a divider; all terms fit in 23 bits.
      // Strict compares keep both outputs off at exact equality of the levels.
      backup_engage    <= backup_enable &&
                          (scale_pct(bus_voltage_mv, CBWC_FULL_PCT) <
                           scale_pct(input_voltage_regulation_limit, ratio_pct));  // R1
      overvoltage_trip <= (input_voltage_mv > ovp_level_mv);  // R3
    end
  end

  // Read port; unmapped addresses answer zero rather than stale data.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata       <= CBWC_UNMAPPED_READ;
      reg_rdata_valid <= 1'b0;
    end else if (enable) begin
      // Read data holds between reads so a slow consumer still finds it.
      reg_rdata_valid <= reg_req.read;
      if (reg_req.read) begin
        case (reg_req.addr)
          CBWC_ADDR_BACKUP_OVP_WATCHDOG: reg_rdata <= ctrl_a;
          CBWC_ADDR_ADAPTER_SHIPSWITCH:  reg_rdata <= ctrl_b;
          default:                       reg_rdata <= CBWC_UNMAPPED_READ;
        endcase
      end
    end
  end

endmodule : cbwc_top

// File: test/cbwc_properties.sv
// Checker for the backup, watchdog, detection and ship-switch control slice.
`timescale 1ns/100ps
module cbwc_properties
  import cbwc_pkg::*;
#(
  parameter longint WD_BASE_CYCLES    = 10,
  parameter longint SHIP_DELAY_CYCLES = 20
) (
  input wire logic          clock,
  input wire logic          reset_n,
  input wire logic          enable,
  input wire cbwc_reg_req_t reg_req,
  input wire logic          register_reset_request,
  input wire logic          backup_enable,
  input wire logic [15:0]   bus_voltage_mv,
  input wire logic [15:0]   input_voltage_regulation_limit,
  input wire logic [15:0]   input_voltage_mv,
  input wire logic          backup_engage,
  input wire logic          overvoltage_trip,
  input wire logic          watchdog_expired,
  input wire logic          detection_start,
  input wire logic          hv_port_handshake_enable,
  input wire logic          hv_port_nine_volt_enable,
  input wire logic          hv_port_twelve_volt_enable,
  input wire logic          ship_action_strobe,
  input wire logic [1:0]    ship_action_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // A write to the second register that a register reset does not override.
  wire w11 = enable && reg_req.write && reg_req.addr == 8'h11 && !register_reset_request;
  // A bypassed ship request that no later write cancels.
  sequence ship_now_s;
    w11 && reg_req.wdata[0] && reg_req.wdata[2:1] != 2'h0 ##1
    enable && !w11 && !register_reset_request;
  endsequence
  a_force_detect_start: assert property (w11 && reg_req.wdata[7] |=> detection_start)
    else $error("Forced detection write gave no start pulse.");
  a_hv_write_mirror: assert property (w11 |=>
    {hv_port_twelve_volt_enable, hv_port_nine_volt_enable, hv_port_handshake_enable}
    == $past(reg_req.wdata[5:3])) else $error("High-voltage enables differ from write.");
  a_regreset_hv_clear: assert property (enable && register_reset_request |=>
    !(hv_port_handshake_enable || hv_port_nine_volt_enable || hv_port_twelve_volt_enable))
    else $error("Register reset left a high-voltage enable set.");
  a_ship_no_delay: assert property (ship_now_s |=> ship_action_strobe &&
    ship_action_mode == $past(reg_req.wdata[2:1], 2)) else $error("Bypassed ship action late.");
  a_mode_hold: assert property ($past(reset_n) && !ship_action_strobe |->
    $stable(ship_action_mode)) else $error("Ship mode changed without an action.");
  a_expiry_gap: assert property (watchdog_expired |=> !watchdog_expired [*8])
    else $error("Watchdog expiry pulses too close.");
  a_backup_off: assert property (enable && !backup_enable |=> !backup_engage)
    else $error("Backup engaged while disabled.");
  a_backup_full: assert property (enable && bus_voltage_mv >= input_voltage_regulation_limit
    |=> !backup_engage) else $error("Backup engaged at or above the full limit.");
  a_backup_low: assert property (enable && backup_enable &&
    32'(bus_voltage_mv) * 32'h64 < 32'(input_voltage_regulation_limit) * 32'h28
    |=> backup_engage) else $error("Backup not engaged below the lowest ratio.");
  a_ovp_low: assert property (enable && input_voltage_mv <= 16'h1B58 |=> !overvoltage_trip)
    else $error("Over-voltage trip below the lowest level.");
  a_ovp_high: assert property (enable && input_voltage_mv > 16'h6590 |=> overvoltage_trip)
    else $error("No over-voltage trip above the highest level.");
  c_expiry: cover property (watchdog_expired);
  c_power_reset: cover property (ship_action_strobe && ship_action_mode == 2'h3);
  c_detect: cover property (detection_start);
endmodule : cbwc_properties

bind cbwc_top cbwc_properties #(.WD_BASE_CYCLES(WD_BASE_CYCLES),
  .SHIP_DELAY_CYCLES(SHIP_DELAY_CYCLES)) cbwc_properties_inst (.*);

// File: test/cbwc_host_model.sv
// Host processor model that issues register reads and writes.
`timescale 1ns/100ps
module cbwc_host_model
  import cbwc_pkg::*;
(
  input  wire logic       clock,
  output cbwc_reg_req_t   reg_req,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid
);
  initial reg_req = '{write: 1'b0, read: 1'b0, addr: 8'hFF, wdata: 8'hFF};
  // Idle address and data are inverted so a stale value never passes for a live one.
  task automatic release_bus();
    reg_req.write = 1'b0;
    reg_req.read  = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : release_bus
  // Callers enter just after an edge; the strobe is taken at the next edge.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    reg_req = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    #1;
    release_bus();
    // One idle edge, so a following call never re-raises the strobe in the same step.
    @(posedge clock);
    #1;
  endtask : write_reg
  // The answer is sampled once, just after the taking edge, with no wait on valid.
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
    reg_req = '{write: 1'b0, read: 1'b1, addr: addr, wdata: ~reg_req.wdata};
    @(posedge clock);
    #1;
    release_bus();
    // The registered answer stands in the cycle after the taking edge.
    valid = reg_rdata_valid;
    data  = reg_rdata;
    @(posedge clock);
    #1;
  endtask : read_reg
endmodule : cbwc_host_model

// File: test/tb.sv
// Self-checking bench for the control slice.
`timescale 1ns/100ps
module tb;
  import cbwc_pkg::*;
  localparam longint WD_N = 10; // Short half-second tick keeps the run brief.
  localparam longint SD_N = 20; // Short ship delay.
  logic clock, reset_n, enable, rrr, benable, plug, ddone, rvalid;
  logic engage, trip, expired, dstart, hvh, hv9, hv12, sstb;
  logic [15:0] bus_mv, lim_mv, in_mv;
  logic [7:0] rdata;
  logic [1:0] smode;
  cbwc_reg_req_t req;
  int n_mismatch = 0, n_tests = 0, seed = 32'hC3E2, cnt, r, m10, m11, n_start = 0;
  int mult[8] = '{0, 1, 2, 4, 40, 80, 160, 320};
  int pct[4] = '{40, 60, 80, 100};
  int ovp[4] = '{26000, 22000, 12000, 7000};
  cbwc_top #(.WD_BASE_CYCLES(WD_N), .SHIP_DELAY_CYCLES(SD_N)) cbwc_top_inst (
    .clock(clock), .reset_n(reset_n), .enable(enable), .reg_req(req), .reg_rdata(rdata),
    .reg_rdata_valid(rvalid), .register_reset_request(rrr), .backup_enable(benable),
    .bus_voltage_mv(bus_mv), .input_voltage_regulation_limit(lim_mv),
    .input_voltage_mv(in_mv), .source_plugged(plug), .detection_done(ddone),
    .backup_engage(engage), .overvoltage_trip(trip), .watchdog_expired(expired),
    .detection_start(dstart), .hv_port_handshake_enable(hvh), .hv_port_nine_volt_enable(hv9),
    .hv_port_twelve_volt_enable(hv12), .ship_action_strobe(sstb), .ship_action_mode(smode));
  cbwc_host_model cbwc_host_model_inst (.clock(clock), .reg_req(req), .reg_rdata(rdata),
    .reg_rdata_valid(rvalid));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Counts detection launch pulses, sampled as a flop would see them.
  always @(posedge clock) if (dstart === 1'b1) n_start++;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cbwc_host_model_inst.write_reg(a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    cbwc_host_model_inst.read_reg(a, v, ok);
    check("register read", 32'(v), 32'(exp));
    check("read valid", 32'(ok), 32'h1);
  endtask : rdchk
  // Counts cycles until a pulse shows, giving up at the limit.
  task automatic count_to(ref logic sig, input int lim, output int c);
    c = 0;
    while (sig !== 1'b1 && c < lim) begin
      tick(1);
      c++;
    end
  endtask : count_to
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // The whole sequence needs well under 20000 cycles.
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {reset_n, rrr, benable, plug, ddone, bus_mv, lim_mv, in_mv} = '0;
    enable = 1'b1;
    tick(10);
    reset_n = 1'b1;
    rdchk(8'h10, 8'h85);
    rdchk(8'h11, 8'h40);
    rdchk(8'h12, 8'h00);
    wr(8'h10, 8'h8F);
    tick(1);
    rdchk(8'h10, 8'h87);
    wr(8'h10, 8'h80);
    $display("Test reset and kick done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      m10 = r & 8'hF0;
      m11 = (r >> 8) & 8'h79;
      wr(8'h10, 8'(m10));
      wr(8'h11, 8'(m11));
      rdchk(8'h10, 8'(m10));
      rdchk(8'h11, 8'(m11));
      check("hv enables", {hv12, hv9, hvh}, 32'(m11 >> 3) & 7);
    end
    $display("Test random readback done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      wr(8'h10, 8'(r & 8'hF0));
      benable = r[8];
      bus_mv = 16'($random(seed) & 16'h7FFF);
      lim_mv = 16'($random(seed) & 16'h7FFF);
      in_mv = 16'($random(seed) & 16'h7FFF);
      tick(2);
      check("backup", engage, benable && bus_mv * 100 < lim_mv * pct[r[7:6]]);
      check("trip", trip, in_mv > ovp[r[5:4]]);
    end
    $display("Test backup and trip done");
    cnt = n_start;
    wr(8'h11, 8'hC0);
    check("forced start", n_start - cnt, 1);
    tick(1);
    rdchk(8'h11, 8'hC0);
    ddone = 1'b1;
    tick(1);
    ddone = 1'b0;
    rdchk(8'h11, 8'h40);
    for (int a = 1; a >= 0; a--) begin
      wr(8'h11, 8'(a << 6));
      plug = 1'b1;
      tick(1);
      plug = 1'b0;
      check("plug start", dstart, a);
    end
    $display("Test detection done");
    for (int m = 1; m < 4; m++) begin
      wr(8'h11, 8'((m << 1) | 1));
      count_to(sstb, 50, cnt);
      check("ship fast", cnt, 0);
      check("ship mode", smode, m);
    end
    wr(8'h11, 8'h04);
    count_to(sstb, 50, cnt);
    check("ship delayed", cnt, SD_N);
    wr(8'h11, 8'h02);
    tick(5);
    wr(8'h11, 8'h00);
    count_to(sstb, 40, cnt);
    check("ship cancel", cnt, 40);
    $display("Test ship switch done");
    for (int p = 1; p < 8; p++) begin
      wr(8'h11, 8'h38);
      wr(8'h10, 8'(8'h80 | p));
      count_to(expired, 4000, cnt);
      check("expiry", cnt, mult[p] * WD_N - 1);
      rdchk(8'h10, 8'(8'h80 | p));
      rdchk(8'h11, 8'h78);
    end
    wr(8'h10, 8'h80);
    $display("Test watchdog done");
    wr(8'h10, 8'h30);
    wr(8'h11, 8'h38);
    rrr = 1'b1;
    tick(1);
    rrr = 1'b0;
    rdchk(8'h10, 8'h85);
    rdchk(8'h11, 8'h40);
    check("hv cleared", {hv12, hv9, hvh}, 0);
    enable = 1'b0;
    wr(8'h10, 8'h31);
    enable = 1'b1;
    rdchk(8'h10, 8'h85);
    $display("Test register reset done");
    print_verdict();
  end
endmodule : tb
